// [include/twm_map.vh]
// register map, field positions, reset values and timing of the two-wire master
// How it works
// - stop during read with unread byte: last byte overwrites holding, overrun stays clear
// - writing master disable freezes any transfer in progress at once
// - disabling leaves transfer complete and tx holding empty flags untouched
// - status read between not_ack_flag detection and completion loses the not_ack_flag flag
// - completion and not_ack_flag set together; reading status clears not_ack_flag
// - receive holding loads on every byte whatever the direction
// - first transmit byte after a receive overwrites the held byte
// - such an overwrite sets neither rx holding full nor overrun
`ifndef TWM_MAP_VH
`define TWM_MAP_VH
`define TWM_CONTROL_REG 12'h000
`define TWM_CLKDIV_REG 12'h004
`define TWM_STATUS_REG 12'h008
`define TWM_IMASK_REG 12'h00C
`define TWM_TX_REG 12'h010
`define TWM_RX_REG 12'h014
`define TWM_ADDR_REG 12'h018
`define TWM_CR_START 0
`define TWM_CR_STOP 1
`define TWM_CR_MEN 2
`define TWM_CR_MDIS 3
`define TWM_SR_TRANSFER_COMPLETE_FLAG 0
`define TWM_SR_RXFULL 1
`define TWM_SR_TXEMPTY 2
`define TWM_SR_OVR 6
`define TWM_SR_NOT_ACK_FLAG 8
`define TWM_SR_RESET 9'h005
`define TWM_DIV_RESET 19'h00101
`define TWM_DIV_LIMIT 8191
`endif

// [hdl/twm_master.v]
// two-wire master controller with apb register access
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "twm_map.vh"
module twm_master (
	input wire pclk,
	input wire presetn,
	input wire clk_en,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire scl_in,
	output reg scl_out,
	output reg scl_oe,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe,
	output reg irq
);
	localparam ST_IDLE = 3'h0;
	localparam ST_START = 3'h1;
	localparam ST_BIT = 3'h2;
	localparam ST_ACK = 3'h3;
	localparam ST_STOP = 3'h4;
	reg [1:0] sda_sync;
	reg [1:0] scl_sync;
	reg enabled;
	reg [7:0] low_period_divider;
	reg [7:0] high_period_divider;
	reg [2:0] divider_exponent;
	reg [8:0] status_reg;
	reg [8:0] imask;
	reg [7:0] tx_data;
	reg [7:0] receive_holding_reg;
	reg [7:0] addr_dir;
	reg [2:0] state;
	reg [15:0] tick;
	reg phase;
	reg [3:0] bitn;
	reg [7:0] shifter;
	reg reading;
	reg addr_phase;
	reg stop_req;
	reg not_ack_flag_seen;
	// register select, used only by the freeze strobe; the decode below compares paddr directly
	function hit;
		input [11:0] a;
		input [11:0] b;
		begin
			hit = (a == b);
		end
	endfunction
	// only the second sync stage feeds logic
	wire sda_s = sda_sync[1];
	wire wr = psel & penable & pwrite & pready;
	wire rd = psel & penable & ~pwrite & pready;
	wire frozen = ~enabled;
	wire [15:0] half = phase ? ({8'h00, high_period_divider} << divider_exponent)
		: ({8'h00, low_period_divider} << divider_exponent);
	wire tick_done = (tick >= half);
	wire [8:0] flags = status_reg;
	// disable takes hold in the write cycle itself, not one tick later
	wire mdis_now = wr & hit(paddr, `TWM_CONTROL_REG) & pwdata[`TWM_CR_MDIS];
	// one status bit set in hardware never loses to a read clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sda_sync <= 2'h3;
			scl_sync <= 2'h3;
			enabled <= 1'b0;
			{divider_exponent, high_period_divider, low_period_divider} <= `TWM_DIV_RESET;
			status_reg <= `TWM_SR_RESET;
			imask <= 9'h000;
			tx_data <= 8'h00;
			receive_holding_reg <= 8'h00;
			addr_dir <= 8'h00;
			state <= ST_IDLE;
			tick <= 16'h0000;
			phase <= 1'b0;
			bitn <= 4'h0;
			shifter <= 8'h00;
			reading <= 1'b0;
			addr_phase <= 1'b0;
			stop_req <= 1'b0;
			not_ack_flag_seen <= 1'b0;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			scl_out <= 1'b1;
			scl_oe <= 1'b0;
			sda_out <= 1'b1;
			sda_oe <= 1'b0;
			irq <= 1'b0;
		end else if (clk_en) begin
			sda_sync <= {sda_sync[0], sda_in};
			scl_sync <= {scl_sync[0], scl_in};
			pready <= psel & ~penable;
			pslverr <= 1'b0;
			irq <= |(status_reg & imask);
			if (psel & ~penable & ~pwrite) begin
				if (paddr == `TWM_CONTROL_REG) prdata <= {31'h0, enabled};
				else if (paddr == `TWM_CLKDIV_REG)
					prdata <= {13'h0, divider_exponent, high_period_divider, 8'h00}
						| {24'h0, low_period_divider};
				else if (paddr == `TWM_STATUS_REG) prdata <= {23'h0, flags};
				else if (paddr == `TWM_IMASK_REG) prdata <= {23'h0, imask};
				else if (paddr == `TWM_RX_REG) prdata <= {24'h0, receive_holding_reg};
				else if (paddr == `TWM_ADDR_REG) prdata <= {24'h0, addr_dir};
				else prdata <= 32'h0000_0000;
			end
			if (psel & ~penable & (paddr > `TWM_ADDR_REG)) pslverr <= 1'b0;
			if (rd && paddr == `TWM_STATUS_REG) begin
				status_reg[`TWM_SR_NOT_ACK_FLAG] <= 1'b0;
				status_reg[`TWM_SR_OVR] <= 1'b0;
				if (state != ST_IDLE) not_ack_flag_seen <= 1'b0;
			end
			if (rd && paddr == `TWM_RX_REG) status_reg[`TWM_SR_RXFULL] <= 1'b0;
			if (wr && paddr == `TWM_CLKDIV_REG) begin
				low_period_divider <= pwdata[7:0];
				high_period_divider <= pwdata[15:8];
				divider_exponent <= pwdata[18:16];
			end
			if (wr && paddr == `TWM_IMASK_REG) imask <= pwdata[8:0];
			if (wr && paddr == `TWM_ADDR_REG) addr_dir <= pwdata[7:0];
			if (wr && paddr == `TWM_TX_REG) begin
				tx_data <= pwdata[7:0];
				status_reg[`TWM_SR_TXEMPTY] <= 1'b0;
			end
			if (wr && paddr == `TWM_CONTROL_REG) begin
				// no flag reset and no bus release: transfer just stops
				if (pwdata[`TWM_CR_MDIS]) enabled <= 1'b0;
				else if (pwdata[`TWM_CR_MEN]) enabled <= 1'b1;
				// a stop with no frame running is dropped, else it would end the next one
				if (pwdata[`TWM_CR_STOP] && state != ST_IDLE) stop_req <= 1'b1;
				if (pwdata[`TWM_CR_START] && state == ST_IDLE && enabled) begin
					state <= ST_START;
					tick <= 16'h0000;
					phase <= 1'b1;
					status_reg[`TWM_SR_TRANSFER_COMPLETE_FLAG] <= 1'b0;
					reading <= addr_dir[0];
					addr_phase <= 1'b1;
					shifter <= addr_dir;
					not_ack_flag_seen <= 1'b0;
					sda_oe <= 1'b1;
					sda_out <= 1'b0;
				end
			end
			// bus timing: each half period lasts half plus one clock
			if (!frozen && !mdis_now && state != ST_IDLE) begin
				tick <= tick_done ? 16'h0000 : tick + 16'h0001;
				if (tick_done) begin
					phase <= ~phase;
					case (state)
						ST_START: begin
							scl_oe <= 1'b1;
							scl_out <= 1'b0;
							phase <= 1'b0;
							state <= ST_BIT;
							bitn <= 4'h0;
						end
						ST_BIT: begin
							scl_out <= ~phase;
							if (!phase) begin
								sda_oe <= ~(reading & ~addr_phase);
								sda_out <= shifter[7];
							end else begin
								shifter <= {shifter[6:0], sda_s};
								bitn <= bitn + 4'h1;
								if (bitn == 4'h7) state <= ST_ACK;
							end
						end
						ST_ACK: begin
							scl_out <= ~phase;
							if (!phase) begin
								sda_oe <= reading & ~addr_phase;
								// master naks the last byte it reads
								sda_out <= stop_req;
							end else begin
								// loaded for any direction, so tx bytes land here too
								receive_holding_reg <= shifter;
								if (reading & ~addr_phase)
									status_reg[`TWM_SR_RXFULL] <= 1'b1;
								// overrun never flagged; stop on read silently loses
								if (!(reading & ~addr_phase) & sda_s) not_ack_flag_seen <= 1'b1;
								addr_phase <= 1'b0;
								if (!(reading & ~addr_phase)) begin
									shifter <= tx_data;
									status_reg[`TWM_SR_TXEMPTY] <= 1'b1;
								end else shifter <= 8'hFF;
								bitn <= 4'h0;
								if (stop_req | (!(reading & ~addr_phase) & sda_s))
									state <= ST_STOP;
								else state <= ST_BIT;
							end
						end
						ST_STOP: begin
							if (!phase) begin
								sda_oe <= 1'b1;
								sda_out <= 1'b0;
								scl_out <= 1'b1;
							end else begin
								sda_oe <= 1'b0;
								sda_out <= 1'b1;
								scl_oe <= 1'b0;
								state <= ST_IDLE;
								stop_req <= 1'b0;
								status_reg[`TWM_SR_TRANSFER_COMPLETE_FLAG] <= 1'b1;
								status_reg[`TWM_SR_NOT_ACK_FLAG] <= not_ack_flag_seen;
							end
						end
						default: state <= ST_IDLE;
					endcase
				end
			end
		end
	end
endmodule // twm_master

// [tb/twm_chk.sv]
// port assertions for the two-wire master
`timescale 1ns/1ps
module twm_chk (
	input wire pclk,
	input wire presetn,
	input wire clk_en,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire scl_out,
	input wire scl_oe,
	input wire sda_out,
	input wire sda_oe
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = psel && penable && pready;
	wire [3:0] pins = {scl_out, scl_oe, sda_out, sda_oe};
	sequence s_st; acc && !pwrite && paddr == 12'h008; endsequence
	property p_rdy; psel && !penable && clk_en |=> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready");
	property p_err; pready |-> !pslverr; endproperty
	a_err: assert property (p_err) else $error("error flagged");
	property p_nk; s_st ##0 prdata[8] |-> prdata[0]; endproperty
	a_nk: assert property (p_nk) else $error("not_ack_flag alone");
	property p_nkc; s_st ##3 s_st |-> !prdata[8]; endproperty
	a_nkc: assert property (p_nkc) else $error("not_ack_flag kept");
	property p_ovr; s_st |-> !prdata[6]; endproperty
	a_ovr: assert property (p_ovr) else $error("overrun set");
	// freeze holds the pins stable for six cycles after the disable write
	property p_dis; acc && pwrite && paddr == 12'h000 && pwdata[3] |=> $stable(pins)[*6]; endproperty
	a_dis: assert property (p_dis) else $error("bus moved");
	property p_unm; acc && !pwrite && paddr == 12'h01C |-> prdata == 32'h0; endproperty
	a_unm: assert property (p_unm) else $error("hole read");
	property p_frz; !clk_en |=> $stable(pins); endproperty
	a_frz: assert property (p_frz) else $error("moved while held");
endmodule // twm_chk
bind twm_master twm_chk i_twm_chk (.*);

// [tb/twm_slave.sv]
// two-wire slave: acks or naks, returns one byte
`timescale 1ns/1ps
module twm_slave (
	input wire scl,
	input wire sda,
	input wire nak,
	input wire [7:0] rd_byte,
	output logic sda_low
);
	int f = 0;
	logic rd = 0;
	logic [7:0] sh = 0;
	initial sda_low = 0;
	always @(negedge sda) if (scl === 1'b1) f = 0;
	always @(posedge scl) sh = {sh[6:0], sda};
	// ninth slot of each byte is the acknowledge
	always @(negedge scl) begin
		f = f + 1;
		if (f == 9) rd = sh[0];
		if ((f - 1) % 9 == 8) sda_low <= !nak && !(rd && f > 9);
		else sda_low <= rd && f > 9 && !rd_byte[7 - (f - 1) % 9];
	end
endmodule // twm_slave

// [tb/tb.sv]
// register tasks and frame scenarios for the two-wire master
`timescale 1ns/1ps
`include "twm_map.vh"
module tb;
	logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, nak = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, rd, st;
	logic [7:0] rd_byte = 8'hC3;
	wire [31:0] prdata;
	wire pready, scl_out, scl_oe, sda_out, sda_oe, irq, s_low;
	// open drain with pull-ups
	// slow clock line so data always leads the slave's sampling edge
	wire #10 scl = !(scl_oe && !scl_out);
	wire sda = !(sda_oe && !sda_out) && !s_low;
	int err_count = 0, n_tests = 0;
	twm_master i_twm_master (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
	twm_slave i_twm_slave (.scl(scl), .sda(sda), .nak(nak), .rd_byte(rd_byte), .sda_low(s_low));
	initial forever #50 pclk = ~pclk;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic final_report;
		$display("compares %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			err_count++;
			final_report;
		end
		rd = prdata;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wait_irq;
		int i;
		for (i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge pclk);
		if (i == 3000) begin
			err_count++;
			final_report;
		end
	endtask
	// waits on interrupts; only a peek frame reads status mid frame
	task automatic frame(input logic [31:0] ad, input logic [31:0] tx, input logic peek);
		apb(1, `TWM_ADDR_REG, ad);
		apb(1, `TWM_TX_REG, tx);
		apb(1, `TWM_IMASK_REG, 32'h4);
		apb(1, `TWM_CONTROL_REG, 32'h5);
		wait_irq;
		if (peek) apb(0, `TWM_STATUS_REG, 0);
		else apb(1, `TWM_CONTROL_REG, 32'h2);
		apb(1, `TWM_IMASK_REG, 32'h1);
		repeat (2) @(posedge pclk);
		wait_irq;
		apb(1, `TWM_IMASK_REG, 32'h0);
		repeat (2) @(posedge pclk);
		chk(irq, 0);
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1;
		apb(0, `TWM_STATUS_REG, 0);
		chk(rd, `TWM_SR_RESET);
		apb(1, 12'h01C, 32'hFFFFFFFF);
		apb(0, 12'h01C, 0);
		chk(rd, 0);
		apb(1, `TWM_CLKDIV_REG, 32'h00000404);
		apb(1, `TWM_CONTROL_REG, 32'h4);
		nak <= 1;
		frame(32'hA4, 32'h5A, 0);
		apb(0, `TWM_STATUS_REG, 0);
		chk({rd[8], rd[0]}, 2'b11);
		apb(0, `TWM_STATUS_REG, 0);
		chk(rd[8], 0);
		frame(32'hA4, 32'h5A, 1);
		apb(0, `TWM_STATUS_REG, 0);
		chk({rd[8], rd[0]}, 2'b01);
		$display("not_ack_flag test done");
		nak <= 0;
		fork
			frame(32'hA5, 0, 0);
			begin
				repeat (40) @(posedge pclk);
				clk_en <= 0;
				repeat (3) @(posedge pclk);
				clk_en <= 1;
			end
		join
		// received byte left unread on purpose
		frame(32'hA4, 32'h96, 0);
		apb(0, `TWM_STATUS_REG, 0);
		chk(rd[6], 0);
		st = rd;
		apb(0, `TWM_RX_REG, 0);
		chk(rd[7:0], 8'h96);
		$display("holding test done");
		apb(1, `TWM_CONTROL_REG, 32'h8);
		apb(0, `TWM_STATUS_REG, 0);
		chk({rd[2], rd[0]}, {st[2], st[0]});
		repeat (6) @(posedge pclk);
		apb(1, `TWM_CONTROL_REG, 32'h4);
		apb(1, `TWM_CONTROL_REG, 32'h5);
		repeat (30) @(posedge pclk);
		apb(1, `TWM_CONTROL_REG, 32'h8);
		st = {scl_out, scl_oe, sda_out, sda_oe};
		repeat (10) @(posedge pclk);
		chk({scl_out, scl_oe, sda_out, sda_oe}, st);
		$display("disable test done");
		final_report;
	end
endmodule // tb
